// ### rtl/fprb_defines.svh
// offsets, field positions, reset values and codes of the permission register bank
`ifndef FPRB_DEFINES_SVH
`define FPRB_DEFINES_SVH

`define FPRB_ADDR_W 12
`define FPRB_OFF_CTRL 12'h514
`define FPRB_OFF_PERM 12'h518
`define FPRB_OFF_STAT 12'h51c

`define FPRB_CTRL_RESET 32'h00050002
`define FPRB_MODE_LSB 0
`define FPRB_MODE_MSB 1
`define FPRB_OVR_BIT 4
`define FPRB_VAL_LSB 16
`define FPRB_VAL_MSB 31
`define FPRB_MODE_RESET 2'h2
`define FPRB_OVR_RESET 1'h0
`define FPRB_VAL_RESET 16'h0005

`define FPRB_MODE_OFF 2'h0
`define FPRB_MODE_NORMAL 2'h1
`define FPRB_MODE_EXTENDED 2'h2

`define FPRB_WO_LSB 0
`define FPRB_WO_MSB 7
`define FPRB_W1_LSB 8
`define FPRB_W1_MSB 15
`define FPRB_RW1_LSB 16
`define FPRB_RW1_MSB 23
`define FPRB_PERM_RESET 8'h00

`define FPRB_STAT_W1_BIT 0
`define FPRB_STAT_RW1_BIT 1
`define FPRB_STAT_MODE_LSB 2
`define FPRB_STAT_MODE_MSB 3
`define FPRB_STAT_CNT_LSB 8
`define FPRB_STAT_CNT_MSB 15
`define FPRB_STAT_RESET 16'h0000
`define FPRB_CNT_ONE 8'h01

`define FPRB_RESP_OKAY 2'h0
`define FPRB_RESP_SLVERR 2'h2

`endif

// ### rtl/fprb_pkg.sv
// types and helper functions of the permission register bank
package fprb_pkg;

  typedef enum logic [2:0] {FPRB_RO, FPRB_WO, FPRB_RW, FPRB_W1, FPRB_RW1} fprb_perm_e;

  function automatic logic fprb_is_once(input fprb_perm_e s);
    fprb_is_once = (s == FPRB_W1) || (s == FPRB_RW1);
  endfunction : fprb_is_once

  // byte-lane merge of new data into the present word
  function automatic logic [31:0] fprb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    fprb_merge = r;
  endfunction : fprb_merge

  // true when any enabled byte lane overlaps bits lsb..msb
  function automatic logic fprb_touch(input logic [3:0] strb, input int lsb, input int msb);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (strb[i] && (i * 8 <= msb) && (i * 8 + 7 >= lsb)) begin
        hit = 1'b1;
      end
    end
    fprb_touch = hit;
  endfunction : fprb_touch

endpackage : fprb_pkg

// ### rtl/fprb_field.sv
// one register field with its own access permission scheme
`timescale 1ns/1ps
`default_nettype none
module fprb_field
  import fprb_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter fprb_perm_e SCHEME = FPRB_RW,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // write side
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] wrData,
  // live value for read-only fields
  input wire logic [WIDTH-1:0] hwValue,
  // state
  output logic [WIDTH-1:0] stored,
  output logic [WIDTH-1:0] readBack,
  output logic locked
);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      locked <= 1'b0;
    end else if (wrEn && fprb_is_once(SCHEME)) begin
      locked <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stored <= RESET_VAL;
    end else if (SCHEME == FPRB_RO) begin
      stored <= hwValue; // writes never reach a read-only field
    end else if (wrEn && !(fprb_is_once(SCHEME) && locked)) begin
      stored <= wrData;
    end
  end

  // undefined reads are returned as zero
  always_comb begin
    case (SCHEME)
      FPRB_WO: readBack = '0;
      FPRB_W1: readBack = '0;
      default: readBack = stored;
    endcase
  end

endmodule : fprb_field
`default_nettype wire

// ### rtl/fprb_axil_slave.sv
// AXI4-Lite slave front end: channel handshakes, held request, registered answers
`timescale 1ns/1ps
`default_nettype none
`include "fprb_defines.svh"
module fprb_axil_slave #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic wrFire,
  output logic [ADDR_W-1:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrErr,
  output logic [ADDR_W-1:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);

  logic rdPend;

  // a ready that is low means that channel's item is held
  assign wrFire = !awready && !wready && !bvalid;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      awready <= 1'b1;
      wrAddr <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      wrAddr <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wready <= 1'b1;
      wrData <= '0;
      wrStrb <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wrData <= wdata;
      wrStrb <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= `FPRB_RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp <= wrErr ? `FPRB_RESP_SLVERR : `FPRB_RESP_OKAY;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // read data is taken one cycle after the address so the mux sees a held address
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      arready <= 1'b1;
      rdPend <= 1'b0;
      rdAddr <= '0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `FPRB_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rdPend <= 1'b1;
      rdAddr <= araddr;
    end else if (rdPend) begin
      rdPend <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdErr ? '0 : rdData;
      rresp <= rdErr ? `FPRB_RESP_SLVERR : `FPRB_RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule : fprb_axil_slave
`default_nettype wire

// ### rtl/fprb_regbank.sv
// field permission register bank with AXI4-Lite access
`timescale 1ns/1ps
`default_nettype none
`include "fprb_defines.svh"
module fprb_regbank
  import fprb_pkg::*;
#(
  parameter int ADDR_W = `FPRB_ADDR_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // feature controls
  output logic featureEnable,
  output logic extendedOn,
  output logic overrideOn,
  output logic [15:0] featureValue,
  // permission demo fields
  output logic [7:0] woValue,
  output logic [7:0] w1Value,
  output logic [7:0] rw1Value
);

  logic wrFire;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrErr;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;
  logic rdErr;
  logic hitCtrlW;
  logic hitPermW;
  logic hitStatW;
  logic [31:0] ctrlWord;
  logic [31:0] permStored;
  logic [31:0] ctrlNew;
  logic [31:0] permNew;
  logic [1:0] mode;
  logic [1:0] modeRd;
  logic ovr;
  logic ovrRd;
  logic [15:0] valRd;
  logic [7:0] woRd;
  logic [7:0] w1Rd;
  logic [7:0] rw1Rd;
  logic w1Locked;
  logic rw1Locked;
  logic [15:0] statLive;
  logic [15:0] statRd;
  logic [7:0] writeCount;

  fprb_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
    .ref_clk(ref_clk),
    .reset(reset),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wrFire(wrFire),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrErr(wrErr),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdErr(rdErr)
  );

  //////////////////////////////////////////////////////////////////////////////
  // write decode

  assign hitCtrlW = wrFire && (wrAddr == `FPRB_OFF_CTRL);
  assign hitPermW = wrFire && (wrAddr == `FPRB_OFF_PERM);
  assign hitStatW = wrFire && (wrAddr == `FPRB_OFF_STAT);
  assign wrErr = !((wrAddr == `FPRB_OFF_CTRL) || (wrAddr == `FPRB_OFF_PERM)
                   || (wrAddr == `FPRB_OFF_STAT));

  // byte lanes without strobe keep their old contents
  assign ctrlNew = fprb_merge(ctrlWord, wrData, wrStrb);
  assign permNew = fprb_merge(permStored, wrData, wrStrb);

  //////////////////////////////////////////////////////////////////////////////
  // feature control register

  fprb_field #(.WIDTH(2), .SCHEME(FPRB_RW), .RESET_VAL(`FPRB_MODE_RESET)) u_mode (
    .ref_clk(ref_clk),
    .reset(reset),
    .wrEn(hitCtrlW && fprb_touch(wrStrb, `FPRB_MODE_LSB, `FPRB_MODE_MSB)),
    .wrData(ctrlNew[`FPRB_MODE_MSB:`FPRB_MODE_LSB]),
    .hwValue(2'h0),
    .stored(mode),
    .readBack(modeRd),
    .locked()
  );

  // deprecated, still stored and decoded for old software
  fprb_field #(.WIDTH(1), .SCHEME(FPRB_RW), .RESET_VAL(`FPRB_OVR_RESET)) u_ovr (
    .ref_clk(ref_clk),
    .reset(reset),
    .wrEn(hitCtrlW && fprb_touch(wrStrb, `FPRB_OVR_BIT, `FPRB_OVR_BIT)),
    .wrData(ctrlNew[`FPRB_OVR_BIT]),
    .hwValue(1'b0),
    .stored(ovr),
    .readBack(ovrRd),
    .locked()
  );

  fprb_field #(.WIDTH(16), .SCHEME(FPRB_RW), .RESET_VAL(`FPRB_VAL_RESET)) u_val (
    .ref_clk(ref_clk),
    .reset(reset),
    .wrEn(hitCtrlW && fprb_touch(wrStrb, `FPRB_VAL_LSB, `FPRB_VAL_MSB)),
    .wrData(ctrlNew[`FPRB_VAL_MSB:`FPRB_VAL_LSB]),
    .hwValue(16'h0000),
    .stored(featureValue),
    .readBack(valRd),
    .locked()
  );

  // reserved bits are dropped on write and read as zero
  always_comb begin
    ctrlWord = '0;
    ctrlWord[`FPRB_MODE_MSB:`FPRB_MODE_LSB] = modeRd;
    ctrlWord[`FPRB_OVR_BIT] = ovrRd;
    ctrlWord[`FPRB_VAL_MSB:`FPRB_VAL_LSB] = valRd;
  end

  //////////////////////////////////////////////////////////////////////////////
  // permission demonstration register

  fprb_field #(.WIDTH(8), .SCHEME(FPRB_WO), .RESET_VAL(`FPRB_PERM_RESET)) u_wo (
    .ref_clk(ref_clk),
    .reset(reset),
    .wrEn(hitPermW && fprb_touch(wrStrb, `FPRB_WO_LSB, `FPRB_WO_MSB)),
    .wrData(permNew[`FPRB_WO_MSB:`FPRB_WO_LSB]),
    .hwValue(8'h00),
    .stored(woValue),
    .readBack(woRd),
    .locked()
  );

  fprb_field #(.WIDTH(8), .SCHEME(FPRB_W1), .RESET_VAL(`FPRB_PERM_RESET)) u_w1 (
    .ref_clk(ref_clk),
    .reset(reset),
    .wrEn(hitPermW && fprb_touch(wrStrb, `FPRB_W1_LSB, `FPRB_W1_MSB)),
    .wrData(permNew[`FPRB_W1_MSB:`FPRB_W1_LSB]),
    .hwValue(8'h00),
    .stored(w1Value),
    .readBack(w1Rd),
    .locked(w1Locked)
  );

  fprb_field #(.WIDTH(8), .SCHEME(FPRB_RW1), .RESET_VAL(`FPRB_PERM_RESET)) u_rw1 (
    .ref_clk(ref_clk),
    .reset(reset),
    .wrEn(hitPermW && fprb_touch(wrStrb, `FPRB_RW1_LSB, `FPRB_RW1_MSB)),
    .wrData(permNew[`FPRB_RW1_MSB:`FPRB_RW1_LSB]),
    .hwValue(8'h00),
    .stored(rw1Value),
    .readBack(rw1Rd),
    .locked(rw1Locked)
  );

  always_comb begin
    permStored = '0;
    permStored[`FPRB_WO_MSB:`FPRB_WO_LSB] = woValue;
    permStored[`FPRB_W1_MSB:`FPRB_W1_LSB] = w1Value;
    permStored[`FPRB_RW1_MSB:`FPRB_RW1_LSB] = rw1Value;
  end

  //////////////////////////////////////////////////////////////////////////////
  // read-only status

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      writeCount <= '0;
    end else if (wrFire && !wrErr) begin
      writeCount <= writeCount + `FPRB_CNT_ONE;
    end
  end

  always_comb begin
    statLive = '0;
    statLive[`FPRB_STAT_W1_BIT] = w1Locked;
    statLive[`FPRB_STAT_RW1_BIT] = rw1Locked;
    statLive[`FPRB_STAT_MODE_MSB:`FPRB_STAT_MODE_LSB] = mode;
    statLive[`FPRB_STAT_CNT_MSB:`FPRB_STAT_CNT_LSB] = writeCount;
  end

  // one cycle behind the live state; a write here is answered OKAY and dropped
  fprb_field #(.WIDTH(16), .SCHEME(FPRB_RO), .RESET_VAL(`FPRB_STAT_RESET)) u_stat (
    .ref_clk(ref_clk),
    .reset(reset),
    .wrEn(hitStatW),
    .wrData(wrData[15:0]),
    .hwValue(statLive),
    .stored(),
    .readBack(statRd),
    .locked()
  );

  //////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rdData = '0;
    rdErr = 1'b0;
    case (rdAddr)
      `FPRB_OFF_CTRL: rdData = ctrlWord;
      `FPRB_OFF_PERM: rdData = {8'h00, rw1Rd, w1Rd, woRd};
      `FPRB_OFF_STAT: rdData = {16'h0000, statRd};
      default: rdErr = 1'b1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered feature decode

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      featureEnable <= 1'b1;
      extendedOn <= 1'b1;
      overrideOn <= 1'b0;
    end else begin
      featureEnable <= (mode == `FPRB_MODE_NORMAL) || (mode == `FPRB_MODE_EXTENDED);
      extendedOn <= (mode == `FPRB_MODE_EXTENDED);
      overrideOn <= ovr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_ctrl_reset_val: assert property ($past(reset) |-> ctrlWord == `FPRB_CTRL_RESET)
    else $error("control word not at reset value after reset");
  chk_lock_reset: assert property ($past(reset) |-> !w1Locked && !rw1Locked)
    else $error("once-lock not clear after reset");
  chk_mode_decode: assert property (hitCtrlW && wrStrb[0] |=> ##1
      featureEnable == ($past(wrData[1:0], 2) != `FPRB_MODE_OFF && $past(wrData[1:0], 2) != 2'h3)
      && extendedOn == ($past(wrData[1:0], 2) == `FPRB_MODE_EXTENDED))
    else $error("mode write not decoded two cycles later");
  chk_override_store: assert property (hitCtrlW && wrStrb[0] |=> ##1
      overrideOn == $past(wrData[`FPRB_OVR_BIT], 2))
    else $error("override write not reflected");
  chk_value_store: assert property (hitCtrlW && (wrStrb[3:2] == 2'h3) |=>
      featureValue == $past(wrData[`FPRB_VAL_MSB:`FPRB_VAL_LSB]))
    else $error("value field lost written bits");
  chk_wo_store: assert property (hitPermW && wrStrb[0] |=> woValue == $past(wrData[7:0]))
    else $error("write-only field did not store");
  chk_w1_ignore: assert property (w1Locked && hitPermW |=> $stable(w1Value))
    else $error("write-once field changed after first write");
  chk_undef_reads: assert property (rdAddr == `FPRB_OFF_PERM |-> rdData[15:0] == 16'h0000)
    else $error("undefined field reads not zero");
  chk_rw1_first: assert property (!rw1Locked && hitPermW && wrStrb[2] |=>
      rw1Locked && (rw1Value == $past(wrData[`FPRB_RW1_MSB:`FPRB_RW1_LSB])))
    else $error("read-write-once first write not kept");
  chk_rw1_ignore: assert property (rw1Locked && hitPermW |=> $stable(rw1Value))
    else $error("read-write-once field changed after lock");
  chk_field_indep: assert property (hitPermW && wrStrb == 4'h1 |=>
      $stable(w1Value) && $stable(rw1Value) && !$changed(w1Locked))
    else $error("write to one field disturbed another");
  chk_ro_ignore: assert property (hitStatW |=> ##1 statRd[15:8] == $past(writeCount, 1))
    else $error("status write altered read-only field");
  chk_bresp_after: assert property (wrFire |=> bvalid &&
      bresp == $past(wrErr ? `FPRB_RESP_SLVERR : `FPRB_RESP_OKAY))
    else $error("write response missing after write");

  cov_ctrl_write: cover property (hitCtrlW ##[1:20] rvalid && rdata == ctrlWord);
  cov_w1_second: cover property (w1Locked && hitPermW);
  cov_rw1_lock: cover property (!rw1Locked && hitPermW ##1 rw1Locked);
  cov_unmapped: cover property (bvalid && bresp == `FPRB_RESP_SLVERR);

endmodule : fprb_regbank
`default_nettype wire

// ### rtl/fprb_axil_slave_note.sv
// holds no logic; the bus front end is in fprb_axil_slave.sv

// ### verif/fprb_axil_master.sv
// AXI4-Lite master model standing in for processor software
`timescale 1ns/1ps
`default_nettype none
module fprb_axil_master (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // write channels
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // released payload shows the inverse, so a stale word never looks valid
  // caller keeps reserved bits zero in d
  task automatic write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] resp);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    while (reset) @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
      if (!awDone && awready) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!wDone && wready) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    // one edge of gap so no signal is driven twice in a step
    @(posedge ref_clk);
  endtask : write
  //////////////////////////////////////////////////////////////////////////////
  task automatic read(input logic [11:0] a, output logic [1:0] resp, output logic [31:0] d);
    logic arDone;
    arDone = 1'b0;
    while (reset) @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (rvalid) begin
        resp = rresp;
        d = rdata;
        rready <= 1'b0;
        break;
      end
      if (!arDone && arready) begin
        arDone = 1'b1;
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end
    @(posedge ref_clk);
  endtask : read
endmodule : fprb_axil_master
`default_nettype wire

// ### verif/fprb_regbank_tb.sv
// self-checking bench of the permission register bank
`timescale 1ns/1ps
`default_nettype none
`include "fprb_defines.svh"
module fprb_regbank_tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic featureEnable, extendedOn, overrideOn;
  logic [15:0] featureValue;
  logic [7:0] woValue, w1Value, rw1Value;
  int fails = 0;
  int n_tests = 0;
  always #25 ref_clk = ~ref_clk;
  fprb_regbank dut (.ref_clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .featureEnable, .extendedOn, .overrideOn, .featureValue, .woValue, .w1Value,
    .rw1Value);
  fprb_axil_master m (.ref_clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready);
  //////////////////////////////////////////////////////////////////////////////
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word
  task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_resp
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic [1:0] r;
    m.write(a, d, s, r);
    cmp_resp("bresp", er, r);
  endtask : wr
  // mask hides bits whose read value is not fixed
  task automatic rd(input logic [11:0] a, input logic [1:0] er, input logic [31:0] ed,
                    input logic [31:0] mask);
    logic [1:0] r;
    logic [31:0] d;
    m.read(a, r, d);
    cmp_resp("rresp", er, r);
    cmp_word("rdata", ed, d & mask);
  endtask : rd
  task automatic cmp_fields(input logic [31:0] ctl);
    cmp_word("featureValue", {16'h0000, ctl[31:16]}, {16'h0000, featureValue});
    cmp_word("overrideOn", {31'h0, ctl[4]}, {31'h0, overrideOn});
    cmp_word("featureEnable", {31'h0, ctl[1:0] == 2'h1 || ctl[1:0] == 2'h2},
             {31'h0, featureEnable});
    cmp_word("extendedOn", {31'h0, ctl[1:0] == 2'h2}, {31'h0, extendedOn});
  endtask : cmp_fields
  task automatic cmp_perm(input logic [7:0] wo, input logic [7:0] w1, input logic [7:0] rw1);
    cmp_word("woValue", {24'h0, wo}, {24'h0, woValue});
    cmp_word("w1Value", {24'h0, w1}, {24'h0, w1Value});
    cmp_word("rw1Value", {24'h0, rw1}, {24'h0, rw1Value});
  endtask : cmp_perm
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    rd(`FPRB_OFF_CTRL, `FPRB_RESP_OKAY, 32'h00050002, 32'hffffffff);
    cmp_fields(32'h00050002);
    cmp_perm(8'h00, 8'h00, 8'h00);
  endtask : t_reset_values
  task automatic t_modes();
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {16'h1234, 11'h000, 1'b0, 2'h0, 2'(i)};
      wr(`FPRB_OFF_CTRL, v, 4'hf, `FPRB_RESP_OKAY);
      rd(`FPRB_OFF_CTRL, `FPRB_RESP_OKAY, v, 32'hffffffff);
      cmp_fields(v);
    end
  endtask : t_modes
  task automatic t_value_override();
    wr(`FPRB_OFF_CTRL, 32'hffff0011, 4'hf, `FPRB_RESP_OKAY);
    rd(`FPRB_OFF_CTRL, `FPRB_RESP_OKAY, 32'hffff0011, 32'hffffffff);
    cmp_fields(32'hffff0011);
    wr(`FPRB_OFF_CTRL, 32'h00000001, 4'hf, `FPRB_RESP_OKAY);
    cmp_fields(32'h00000001);
  endtask : t_value_override
  // partial strobes touch one byte of the value field only
  task automatic t_strobe();
    wr(`FPRB_OFF_CTRL, 32'h00ab0000, 4'h4, `FPRB_RESP_OKAY);
    rd(`FPRB_OFF_CTRL, `FPRB_RESP_OKAY, 32'h00ab0001, 32'hffffffff);
    wr(`FPRB_OFF_CTRL, 32'hcd000000, 4'h8, `FPRB_RESP_OKAY);
    rd(`FPRB_OFF_CTRL, `FPRB_RESP_OKAY, 32'hcdab0001, 32'hffffffff);
  endtask : t_strobe
  task automatic t_perm();
    wr(`FPRB_OFF_PERM, 32'h00332211, 4'hf, `FPRB_RESP_OKAY);
    rd(`FPRB_OFF_PERM, `FPRB_RESP_OKAY, 32'h00330000, 32'h00ff0000);
    cmp_perm(8'h11, 8'h22, 8'h33);
    wr(`FPRB_OFF_PERM, 32'h00665544, 4'hf, `FPRB_RESP_OKAY);
    rd(`FPRB_OFF_PERM, `FPRB_RESP_OKAY, 32'h00330000, 32'h00ff0000);
    cmp_perm(8'h44, 8'h22, 8'h33);
    rd(`FPRB_OFF_STAT, `FPRB_RESP_OKAY, 32'h00000007, 32'h0000000f);
  endtask : t_perm
  task automatic t_read_only();
    wr(`FPRB_OFF_STAT, 32'h0000ff0f, 4'hf, `FPRB_RESP_OKAY);
    rd(`FPRB_OFF_STAT, `FPRB_RESP_OKAY, 32'h00000007, 32'h0000000f);
  endtask : t_read_only
  task automatic t_unmapped();
    wr(12'h520, 32'h00000000, 4'hf, `FPRB_RESP_SLVERR);
    rd(12'h510, `FPRB_RESP_SLVERR, 32'h00000000, 32'hffffffff);
    rd(`FPRB_OFF_CTRL, `FPRB_RESP_OKAY, 32'hcdab0001, 32'hffffffff);
  endtask : t_unmapped
  // a second reset must reopen the once-fields
  task automatic t_rereset();
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(`FPRB_OFF_CTRL, `FPRB_RESP_OKAY, 32'h00050002, 32'hffffffff);
    wr(`FPRB_OFF_PERM, 32'h000000aa, 4'h1, `FPRB_RESP_OKAY);
    rd(`FPRB_OFF_STAT, `FPRB_RESP_OKAY, 32'h00000000, 32'h00000003);
    wr(`FPRB_OFF_PERM, 32'h00000000, 4'h6, `FPRB_RESP_OKAY);
    wr(`FPRB_OFF_PERM, 32'h00776699, 4'hf, `FPRB_RESP_OKAY);
    cmp_perm(8'h99, 8'h00, 8'h00);
    rd(`FPRB_OFF_STAT, `FPRB_RESP_OKAY, 32'h00000003, 32'h00000003);
  endtask : t_rereset
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset_values();
    t_modes();
    t_value_override();
    t_strobe();
    t_perm();
    t_read_only();
    t_unmapped();
    t_rereset();
    report_and_stop();
  end
  // whole run needs well under a thousand edges
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end
endmodule : fprb_regbank_tb
`default_nettype wire
